// file: src/svwd_filter.sv
// Purpose: Glitch filter for one synchronous input.
// Assumes: Input already synchronous to core_clk.
// Notes:   Output changes only after the input holds a new level long enough.
`timescale 1ns/10ps
module svwd_filter import svwd_pkg::*; #(
	parameter int unsigned WIDTH_CYC = GLITCH_FILTER_CYC,
	parameter logic        INIT      = 1'b1
) (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rst,
	// Data
	input  wire logic din,
	output logic      dout
);
	localparam int unsigned CW = $clog2(WIDTH_CYC + 1);
	logic [CW-1:0] count;

	// A zero width would let every glitch through, so refuse it at build.
	if (WIDTH_CYC < 1) begin
		$error("filter width must be at least one cycle");
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			count <= '0;
			dout <= INIT;
		end else if (din == dout) begin
			count <= '0;
		end else if (count == CW'(WIDTH_CYC)) begin
			count <= '0;
			dout <= din;
		end else begin
			count <= count + CW'(1);
		end
	end
endmodule

// file: src/svwd_pkg.sv
// Purpose: Shared constants and types for the supervisor watchdog block.
// Assumes: core_clk at 250 MHz; bus pins already synchronous to it.
// Notes:   Short intervals are given in their own unit and converted here.
package svwd_pkg;
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned CLK_NS = 4;
	// Nominal intervals in their printed units.
	localparam int unsigned PERIOD_10_MS = 250;
	localparam int unsigned PERIOD_01_MS = 650;
	localparam int unsigned PERIOD_00_MS = 1500;
	localparam int unsigned POWERUP_RESET_MS = 250;
	localparam int unsigned RESET_TIMEOUT_MS = 250;
	localparam int unsigned NV_WRITE_MS = 5;
	localparam int unsigned STANDBY_DELAY_NS = 200;
	localparam int unsigned GLITCH_FILTER_NS = 50;
	localparam int unsigned MISMATCH_BUS_CLOCKS = 9;
	// Cycle counts derived from the clock rate.
	localparam int unsigned CYC_PER_MS = CLK_MHZ * 1000;
	localparam int unsigned STANDBY_DELAY_CYC =
		(STANDBY_DELAY_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned GLITCH_FILTER_CYC =
		(GLITCH_FILTER_NS + CLK_NS - 1) / CLK_NS;
	// Period selector codes.
	localparam logic [1:0] SEL_OFF = 2'h3;
	localparam logic [1:0] SEL_SHORT = 2'h2;
	localparam logic [1:0] SEL_MID = 2'h1;
	localparam logic [1:0] SEL_LONG = 2'h0;
	localparam logic [1:0] SEL_RESET = SEL_OFF;
	// Bus pins bundled together.
	typedef struct packed {
		logic scl;
		logic sda;
	} svwd_bus_type;
endpackage

// file: src/svwd_top.sv
// Purpose: Watchdog, power-up reset and power-state tracking of a supervisor.
// Assumes: Host is a two-wire bus master; SDA is open drain on the board.
// Notes:   Memory array and bus data path lie outside; this tracks states only.
`timescale 1ns/10ps
// Functional notes
// - Selector 11 disables; 10, 01, 00 choose 250 ms, 650 ms, 1.5 s.
// - Reset output held for power-up interval, nominally 250 ms, then freed.
// - All inputs ignored while the reset output is asserted.
// - Start wakes device; wrong device select returns standby nine clocks on.
// - Stop not launching a write returns to standby 200 ns later.
// - Write-ending stop runs a 5 ms self-timed write, active throughout.
// - Input pulses under 50 ns are suppressed by filtering.
// - Reset output refuses bus traffic and abandons a transaction.
module svwd_top import svwd_pkg::*; #(
	parameter int unsigned POWERUP_CYC = POWERUP_RESET_MS * CYC_PER_MS,
	parameter int unsigned RESET_CYC   = RESET_TIMEOUT_MS * CYC_PER_MS,
	parameter int unsigned WRITE_CYC   = NV_WRITE_MS * CYC_PER_MS,
	parameter int unsigned SHORT_CYC   = PERIOD_10_MS * CYC_PER_MS,
	parameter int unsigned MID_CYC     = PERIOD_01_MS * CYC_PER_MS,
	parameter int unsigned LONG_CYC    = PERIOD_00_MS * CYC_PER_MS,
	parameter logic [3:0]  DEV_TYPE    = 4'hA
) (
	// Clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst,
	// Two-wire bus pins and device address strap
	input  wire svwd_bus_type bus_in,
	input  wire logic [1:0]   dev_addr,
	output logic              sda_out,
	output logic              sda_oe,
	// Transaction events from the bus data path
	input  wire logic         write_stop,
	input  wire logic         sel_write,
	input  wire logic [1:0]   sel_value,
	input  wire logic         unlock_step,
	input  wire logic         wd_restart,
	// Supervisor outputs
	output logic              reset_out,
	output logic              active,
	output logic              nv_busy,
	output logic [1:0]        period_sel
);
	typedef enum logic [2:0] {
		ST_STANDBY, ST_ADDR, ST_XFER, ST_LINGER, ST_NVWRITE
	} svwd_state_type;

	localparam int unsigned TW = 32;

	svwd_state_type state;
	logic           scl_f;
	logic           sda_f;
	logic           scl_d;
	logic           sda_d;
	logic           start_ev;
	logic           stop_ev;
	logic           scl_rise;
	logic [3:0]     bit_cnt;
	logic [7:0]     addr_sh;
	logic [TW-1:0]  rst_cnt;
	logic [TW-1:0]  wd_cnt;
	logic [TW-1:0]  st_cnt;
	logic [TW-1:0]  period_cyc;
	logic [1:0]     unlock_cnt;
	logic           powerup_done;

	if (SHORT_CYC == 0 || MID_CYC == 0 || LONG_CYC == 0 ||
		RESET_CYC == 0 || POWERUP_CYC == 0 || WRITE_CYC == 0) begin
		$error("all interval counts must be nonzero");
	end

	// Both bus lines pass the glitch filter before any decoding.
	svwd_filter #(.WIDTH_CYC(GLITCH_FILTER_CYC), .INIT(1'b1)) u_scl (
		.core_clk (core_clk),
		.rst      (rst),
		.din      (bus_in.scl),
		.dout     (scl_f)
	);
	svwd_filter #(.WIDTH_CYC(GLITCH_FILTER_CYC), .INIT(1'b1)) u_sda (
		.core_clk (core_clk),
		.rst      (rst),
		.din      (bus_in.sda),
		.dout     (sda_f)
	);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_f;
			sda_d <= sda_f;
		end
	end

	// Bus events are masked while reset is driven out.
	assign start_ev = !reset_out && scl_f && scl_d && sda_d && !sda_f;
	assign stop_ev  = !reset_out && scl_f && scl_d && !sda_d && sda_f;
	assign scl_rise = !reset_out && scl_f && !scl_d;

	// Reset generator: power-up interval, then one timeout per expiry.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			reset_out <= 1'b1;
			rst_cnt <= '0;
			powerup_done <= 1'b0;
		end else if (reset_out) begin
			if (rst_cnt >= (powerup_done ? TW'(RESET_CYC) - TW'(1)
				: TW'(POWERUP_CYC) - TW'(1))) begin
				reset_out <= 1'b0;
				powerup_done <= 1'b1;
				rst_cnt <= '0;
			end else begin
				rst_cnt <= rst_cnt + TW'(1);
			end
		end else if (period_sel != SEL_OFF &&
			wd_cnt >= period_cyc - TW'(1)) begin
			reset_out <= 1'b1;
			rst_cnt <= '0;
		end
	end

	always_comb begin
		case (period_sel)
			SEL_SHORT: period_cyc = TW'(SHORT_CYC);
			SEL_MID:   period_cyc = TW'(MID_CYC);
			SEL_LONG:  period_cyc = TW'(LONG_CYC);
			default:   period_cyc = '0;
		endcase
	end

	// Watchdog counter restarts on host activity and after each reset.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wd_cnt <= '0;
		end else if (reset_out || wd_restart || period_sel == SEL_OFF) begin
			wd_cnt <= '0;
		end else begin
			wd_cnt <= wd_cnt + TW'(1);
		end
	end

	// Selector write needs three unlock steps first.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			period_sel <= SEL_RESET;
			unlock_cnt <= '0;
		end else if (reset_out) begin
			unlock_cnt <= '0;
		end else if (sel_write) begin
			if (unlock_cnt == 2'h3) begin
				period_sel <= sel_value;
			end
			unlock_cnt <= '0;
		end else if (unlock_step && unlock_cnt != 2'h3) begin
			unlock_cnt <= unlock_cnt + 2'h1;
		end
	end

	// Power-state machine.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state <= ST_STANDBY;
			bit_cnt <= '0;
			addr_sh <= '0;
			st_cnt <= '0;
		end else if (reset_out) begin
			state <= ST_STANDBY;
			bit_cnt <= '0;
			st_cnt <= '0;
		end else begin
			case (state)
				ST_NVWRITE: begin
					if (st_cnt >= TW'(WRITE_CYC) - TW'(1)) begin
						state <= ST_STANDBY;
						st_cnt <= '0;
					end else begin
						st_cnt <= st_cnt + TW'(1);
					end
				end
				default: begin
					if (start_ev) begin
						state <= ST_ADDR;
						bit_cnt <= '0;
					end else if (stop_ev && state != ST_STANDBY) begin
						st_cnt <= '0;
						state <= write_stop ? ST_NVWRITE : ST_LINGER;
					end else if (state == ST_ADDR && scl_rise) begin
						addr_sh <= {addr_sh[6:0], sda_f};
						bit_cnt <= bit_cnt + 4'h1;
						if (bit_cnt == 4'(MISMATCH_BUS_CLOCKS - 1)) begin
							// The shifter still holds the eight address bits
							// here; the ninth rise is the acknowledge slot.
							state <= (addr_sh[7:4] == DEV_TYPE &&
								addr_sh[2:1] == dev_addr) ? ST_XFER
								: ST_STANDBY;
						end
					end else if (state == ST_LINGER) begin
						if (st_cnt >= TW'(STANDBY_DELAY_CYC) - TW'(1)) begin
							state <= ST_STANDBY;
						end else begin
							st_cnt <= st_cnt + TW'(1);
						end
					end
				end
			endcase
		end
	end

	assign active  = state != ST_STANDBY;
	assign nv_busy = state == ST_NVWRITE;
	// The device never pulls SDA here; the data path owns acknowledges.
	assign sda_out = 1'b0;
	assign sda_oe  = 1'b0;
endmodule

// file: verification/svwd_host.sv
// Purpose: Host bus master model on the two-wire pins.
// Assumes: Both lines idle high through pull-ups.
// Notes:   Each bus clock half lasts 20 core cycles, beyond the filter.
`timescale 1ns/10ps
module svwd_host import svwd_pkg::*; (
	// Clock
	input wire logic     core_clk,
	// Bus pins
	output svwd_bus_type bus
);
	initial bus = 2'h3;
	task automatic half();
		repeat (20) @(posedge core_clk);
		#1;
	endtask
	task automatic start();
		bus = 2'h3;
		half();
		bus.sda = 1'h0;
		half();
		bus.scl = 1'h0;
		half();
	endtask
	// The ninth bit releases the data line for the acknowledge.
	task automatic send(input logic [7:0] b);
		for (int i = 8; i >= 0; i--) begin
			bus.sda = (i > 0) ? b[i-1] : 1'h1;
			half();
			bus.scl = 1'h1;
			half();
			bus.scl = 1'h0;
		end
		half();
	endtask
	task automatic stop();
		bus.sda = 1'h0;
		half();
		bus.scl = 1'h1;
		half();
		bus.sda = 1'h1;
		half();
	endtask
	task automatic glitch();
		bus.sda = 1'h0;
		repeat (5) @(posedge core_clk);
		#1;
		bus.sda = 1'h1;
	endtask
endmodule

// file: verification/svwd_properties.sv
// Purpose: Port assertions for the supervisor watchdog.
// Assumes: Shortened counts arrive through the bind.
// Notes:   Helper counters measure busy and reset runs.
`timescale 1ns/10ps
module svwd_properties import svwd_pkg::*; #(
	parameter int unsigned POWERUP_CYC = 200,
	parameter int unsigned RESET_CYC   = 200,
	parameter int unsigned WRITE_CYC   = 100
) (
	// Clock and reset
	input wire logic       core_clk,
	input wire logic       rst,
	// Watched ports
	input wire logic       sel_write,
	input wire logic       active,
	input wire logic       nv_busy,
	input wire logic       reset_out,
	input wire logic [1:0] period_sel
);
	int unsigned nv_cnt;
	int unsigned rs_cnt;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			nv_cnt <= 0;
			rs_cnt <= 0;
		end else begin
			nv_cnt <= nv_busy ? nv_cnt + 1 : 0;
			rs_cnt <= reset_out ? rs_cnt + 1 : 0;
		end
	end
	a_sel_needs_write: assert property (
		period_sel != $past(period_sel) |-> $past(sel_write))
		else $error("selector moved unasked");
	a_sel_frozen: assert property (
		reset_out && sel_write |=> $stable(period_sel))
		else $error("selector moved in reset");
	a_nv_active: assert property (nv_busy |-> active)
		else $error("busy while in standby");
	a_nv_span: assert property (
		$fell(nv_busy) |-> nv_cnt inside {[WRITE_CYC-1:WRITE_CYC+1]})
		else $error("write span wrong");
	a_reset_span: assert property (
		$fell(reset_out) |-> rs_cnt inside {[POWERUP_CYC-1:POWERUP_CYC+1],
		[RESET_CYC-1:RESET_CYC+1]})
		else $error("reset span wrong");
	a_off_quiet: assert property (
		!reset_out && period_sel == SEL_OFF |=> !reset_out)
		else $error("reset while watchdog off");
	a_wake_free: assert property ($rose(active) |-> !reset_out)
		else $error("woke during reset");
	a_abandon_bus: assert property (
		$rose(reset_out) |-> ##[0:2] (!active || nv_busy))
		else $error("transfer kept in reset");
	cover property ($fell(nv_busy));
	cover property ($rose(reset_out));
	cover property ($fell(active) && !nv_busy);
endmodule

// file: verification/test_supervisor_watchdog_reset_timing.sv
// Purpose: Self-checking bench for the supervisor watchdog.
// Assumes: Shortened counts; device address strap starts at 1.
// Notes:   Watchdog periods run from a table of selector codes.
`timescale 1ns/10ps
module test_supervisor_watchdog_reset_timing;
	import svwd_pkg::*;
	typedef struct packed {
		logic [1:0]  sel;
		logic [15:0] cyc;
	} svwd_row_type;
	// Shortened intervals in core cycles, shared by the design and the checks.
	localparam int unsigned T_POWERUP = 200;
	localparam int unsigned T_RESET   = 200;
	localparam int unsigned T_WRITE   = 100;
	localparam int unsigned T_SHORT   = 300;
	localparam int unsigned T_MID     = 500;
	localparam int unsigned T_LONG    = 800;
	svwd_row_type rows [4] = '{'{SEL_SHORT, 16'(T_SHORT)},
		'{SEL_MID, 16'(T_MID)},
		'{SEL_LONG, 16'(T_LONG)},
		'{SEL_OFF, 16'h0000}};
	logic         core_clk = 0;
	logic         rst = 1;
	logic         write_stop = 0;
	logic         sel_write = 0;
	logic         unlock_step = 0;
	logic         wd_restart = 0;
	logic [1:0]   sel_value = 0;
	logic [1:0]   dev_addr = 2'h1;
	svwd_bus_type bus_in;
	logic         sda_out, sda_oe, reset_out, active, nv_busy;
	logic [1:0]   period_sel;
	int           errors = 0, compares = 0, n;
	time          t0;
	svwd_host u_host (.core_clk(core_clk), .bus(bus_in));
	svwd_top #(.POWERUP_CYC(T_POWERUP), .RESET_CYC(T_RESET),
		.WRITE_CYC(T_WRITE), .SHORT_CYC(T_SHORT), .MID_CYC(T_MID),
		.LONG_CYC(T_LONG)) u_dut (
		.core_clk(core_clk), .rst(rst), .bus_in(bus_in),
		.dev_addr(dev_addr), .sda_out(sda_out), .sda_oe(sda_oe),
		.write_stop(write_stop), .sel_write(sel_write),
		.sel_value(sel_value), .unlock_step(unlock_step),
		.wd_restart(wd_restart), .reset_out(reset_out), .active(active),
		.nv_busy(nv_busy), .period_sel(period_sel));
	always #2 core_clk = ~core_clk;
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask
	task automatic step_unlock();
		unlock_step = 1;
		tick(1);
		unlock_step = 0;
		tick(1);
	endtask
	task automatic write_sel(input logic [1:0] v);
		sel_value = v;
		sel_write = 1;
		tick(1);
		sel_write = 0;
		tick(1);
	endtask
	task automatic restart();
		wd_restart = 1;
		tick(1);
		wd_restart = 0;
		tick(1);
	endtask
	task automatic set_sel(input logic [1:0] v);
		repeat (3) step_unlock();
		write_sel(v);
	endtask
	task automatic count_until(input logic lvl, input int lim);
		n = 0;
		while (reset_out !== lvl && n < lim) begin
			tick(1);
			n++;
		end
	endtask
	task automatic give_verdict();
		if (errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		errors++;
		give_verdict();
	end
	initial begin
		tick(20);
		chk({reset_out, active, period_sel}, 4'hB);
		rst = 0;
		t0 = $time;
		set_sel(SEL_SHORT);
		chk(period_sel, SEL_OFF);
		u_host.start();
		chk(active, 1'h0);
		count_until(0, 400);
		n = int'(($time - t0) / 4);
		chk(n >= T_POWERUP - 1 && n <= T_POWERUP + 2, 1'h1);
		foreach (rows[i]) begin
			set_sel(rows[i].sel);
			chk(period_sel, rows[i].sel);
			restart();
			tick(rows[i].cyc / 2);
			restart();
			count_until(1, 900);
			if (rows[i].cyc == 0)
				chk(reset_out, 1'h0);
			else
				chk(n + 4 >= rows[i].cyc && n <= rows[i].cyc + 1, 1'h1);
			count_until(0, 300);
			chk(rows[i].cyc == 0 ||
				(n + 2 >= T_RESET && n <= T_RESET), 1'h1);
		end
		write_sel(SEL_SHORT);
		chk(period_sel, SEL_OFF);
		u_host.start();
		chk(active, 1'h1);
		u_host.send(8'h52);
		chk(active, 1'h0);
		dev_addr = 2'h2;
		u_host.start();
		u_host.send(8'hA2);
		chk(active, 1'h0);
		dev_addr = 2'h1;
		u_host.start();
		u_host.send(8'hA2);
		chk(active, 1'h1);
		u_host.stop();
		chk({active, nv_busy}, 2'h2);
		tick(60);
		chk(active, 1'h0);
		write_stop = 1;
		u_host.start();
		u_host.send(8'hA2);
		u_host.stop();
		chk({active, nv_busy}, 2'h3);
		tick(70);
		chk({active, nv_busy}, 2'h3);
		tick(40);
		chk({active, nv_busy}, 2'h0);
		write_stop = 0;
		u_host.glitch();
		tick(30);
		chk(active, 1'h0);
		set_sel(SEL_SHORT);
		restart();
		u_host.start();
		u_host.send(8'hA2);
		count_until(1, 400);
		tick(3);
		chk(active, 1'h0);
		chk(reset_out, 1'h1);
		chk({sda_out, sda_oe}, 2'h0);
		give_verdict();
	end
endmodule
bind svwd_top svwd_properties #(.POWERUP_CYC(POWERUP_CYC),
	.RESET_CYC(RESET_CYC), .WRITE_CYC(WRITE_CYC)) u_props (
	.core_clk(core_clk), .rst(rst), .sel_write(sel_write),
	.active(active), .nv_busy(nv_busy), .reset_out(reset_out),
	.period_sel(period_sel));
